// *** verilog/frame_defines.svh ***
// register map, frame layout offsets and reset values of the save-frame engine
`ifndef FRAME_DEFINES_SVH
`define FRAME_DEFINES_SVH

// ==========================================================================
// register byte addresses
`define REG_BASE_LO      8'h00
`define REG_BASE_HI      8'h04
`define REG_STACK_LO     8'h08
`define REG_STACK_HI     8'h0c
`define REG_FRAME_SIZE   8'h10
`define REG_FRAME_INDEX  8'h14
`define REG_SELECT       8'h18
`define REG_XSTATE_EN    8'h1c
`define REG_CAPS         8'h20
`define REG_STATUS       8'h24
`define REG_MASK         8'h28
`define REG_STATE        8'h2c

// ==========================================================================
// status bits, mask bits share the layout
`define ST_EXIT_DONE     0
`define ST_RESUME_DONE   1
`define ST_LAYOUT_ERR    2
`define ST_NOTIFY        3
`define ST_WIDTH         4

// ==========================================================================
// frame layout
`define XS_OFFSET        64'h0
`define GPR_REGION_SIZE  64'h00b0
`define GPR_FLAGS_OFS    64'h0080
`define GPR_IP_OFS       64'h0088
`define GPR_OSP_OFS      64'h0090
`define GPR_OFP_OFS      64'h0098
`define GPR_INFO_OFS     64'h00a0
`define INFO_STRB        8'h0f
`define NOTIFY_BYTE      3'd7
`define NOTIFY_BIT       0
`define MISC_COMP_SIZE   64'h0010
`define XS_COMPS         8
// end offset of each extended-state component, entry 0 in the low 16 bits
`define XS_END_TABLE     128'h0b00_0a00_0900_0800_0440_0340_0240_0240

// ==========================================================================
// reset values
`define RST_FRAME_SIZE   32'h0000_1000
`define RST_XSTATE_EN    8'h03
`define RST_CAPS         32'h0000_0001

`endif

// *** verilog/frame_pkg.sv ***
// shared types of the save-frame engine
package frame_pkg;

  // ========================================================================
  // architectural state handed over by the core on an exit
  typedef struct packed {
    logic [15:0][63:0] gpr;
    logic [63:0]       flags;
    logic [63:0]       ip;
    logic [31:0]       exit_info;
  } arch_state_t;

  // outside stack and frame pointers
  typedef struct packed {
    logic [63:0] sp;
    logic [63:0] fp;
  } outside_ptrs_t;

  // one word request towards enclave memory
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [63:0] addr;
    logic [63:0] wdata;
    logic [7:0]  strb;
  } mem_req_t;

  // derived frame geometry
  typedef struct packed {
    logic [63:0] frame_base;
    logic [63:0] gpr_base;
    logic [63:0] misc_base;
    logic [63:0] misc_size;
    logic [63:0] xs_size;
    logic        overlap;
  } layout_t;

  typedef enum logic [3:0] {
    S_IDLE, S_XS, S_MISC, S_GPR, S_RD_OSP, S_RD_OFP, S_RD_INFO, S_WR_INFO,
    S_EN_OSP, S_EN_OFP
  } exit_state_t;

endpackage : frame_pkg

// *** verilog/frame_layout.sv ***
// frame geometry calculator of the save-frame engine
`timescale 1ns/10ps
`default_nettype none
`include "frame_defines.svh"

module frame_layout
  import frame_pkg::*;
#(
  parameter int XS_COMPS = `XS_COMPS
) (
  input  wire logic [63:0]         i_encl_base,
  input  wire logic [63:0]         i_stack_ofs,
  input  wire logic [31:0]         i_frame_size,
  input  wire logic [31:0]         i_frame_index,
  input  wire logic [XS_COMPS-1:0] i_xstate_en,
  input  wire logic [31:0]         i_caps,
  input  wire logic [31:0]         i_select,
  output layout_t                  o_layout
);

  localparam logic [127:0] XS_END = `XS_END_TABLE;

  logic [XS_COMPS-1:0][15:0] comp_end;
  logic [63:0]               frame_base;
  logic [63:0]               xs_size;
  logic [63:0]               misc_size;

  // ========================================================================
  // per-component end offset, zero when the component is not enabled
  genvar g;
  generate
    for (g = 0; g < XS_COMPS; g++) begin : g_comp
      assign comp_end[g] = i_xstate_en[g] ? XS_END[16*g +: 16] : 16'h0;
    end
  endgenerate

  assign frame_base = i_encl_base + i_stack_ofs
                    + 64'(i_frame_index) * 64'(i_frame_size);

  // ========================================================================
  // largest end of the enabled set, non-compacted
  always_comb begin
    xs_size = 64'h0;
    for (int i = 0; i < XS_COMPS; i++) begin
      if (64'(comp_end[i]) > xs_size) begin
        xs_size = 64'(comp_end[i]);
      end
    end
  end

  // size from the highest selected component
  always_comb begin
    misc_size = 64'h0;
    if (i_caps != 32'h0) begin
      for (int i = 0; i < 32; i++) begin
        if (i_select[i]) begin
          misc_size = `MISC_COMP_SIZE * 64'(i + 1);
        end
      end
    end
  end

  // ========================================================================
  // gpr region closes the frame
  always_comb begin
    o_layout.frame_base = frame_base;
    o_layout.gpr_base   = frame_base + 64'(i_frame_size) - `GPR_REGION_SIZE;
    o_layout.misc_base  = o_layout.gpr_base - misc_size;
    o_layout.misc_size  = misc_size;
    o_layout.xs_size    = xs_size;
    o_layout.overlap    = (xs_size + misc_size + `GPR_REGION_SIZE)
                          > 64'(i_frame_size);
  end

endmodule : frame_layout
`default_nettype wire

// *** verilog/frame_engine.sv ***
// asynchronous-exit save-frame engine with ahb-lite register slave
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "frame_defines.svh"

module frame_engine
  import frame_pkg::*;
#(
  parameter int          XS_COMPS = `XS_COMPS,
  parameter logic [31:0] CAPS     = `RST_CAPS
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_hsel,
  input  wire logic [31:0]   i_haddr,
  input  wire logic [1:0]    i_htrans,
  input  wire logic          i_hwrite,
  input  wire logic [2:0]    i_hsize,
  input  wire logic [31:0]   i_hwdata,
  input  wire logic          i_hready,
  output logic [31:0]        o_hrdata,
  output logic               o_hreadyout,
  output logic               o_hresp,
  input  wire logic          i_exit_req,
  input  wire arch_state_t   i_state,
  input  wire logic          i_entry_req,
  input  wire outside_ptrs_t i_entry_ptrs,
  input  wire logic          i_resume_req,
  input  wire logic [63:0]   i_xs_data,
  output logic               o_xs_pop,
  output mem_req_t           o_mem,
  input  wire logic          i_mem_ready,
  input  wire logic [63:0]   i_mem_rdata,
  output outside_ptrs_t      o_restore,
  output logic               o_restore_valid,
  output logic               o_notify,
  output logic               o_busy,
  output logic               o_irq
);

  // ========================================================================
  // declarations
  logic [63:0]         encl_base_reg;
  logic [63:0]         stack_ofs_reg;
  logic [31:0]         frame_size_reg;
  logic [31:0]         frame_index_reg;
  logic [31:0]         select_reg;
  logic [XS_COMPS-1:0] xstate_en_reg;
  logic [`ST_WIDTH-1:0] status_reg;
  logic [`ST_WIDTH-1:0] mask_reg;
  logic [`ST_WIDTH-1:0] events;
  logic                dp_write_reg;
  logic [7:0]          dp_addr_reg;
  logic                addr_phase;
  layout_t             lay;
  layout_t             lay_reg;
  exit_state_t         state_reg;
  exit_state_t         state_next;
  arch_state_t         saved_reg;
  logic [15:0]         cnt_reg;
  logic [15:0]         last_cnt;
  mem_req_t            req_next;
  logic                mem_done;
  logic                step_last;
  logic [31:0]         rd_value;
  logic                sw_write;
  // bus decode and memory handshake
  assign addr_phase = i_hsel && i_hready && i_htrans[1];
  assign sw_write   = dp_write_reg;
  assign mem_done   = o_mem.valid && i_mem_ready;

  // ========================================================================
  // frame geometry
  frame_layout #(
    .XS_COMPS (XS_COMPS)
  ) u_layout (
    .i_encl_base   (encl_base_reg),
    .i_stack_ofs   (stack_ofs_reg),
    .i_frame_size  (frame_size_reg),
    .i_frame_index (frame_index_reg),
    .i_xstate_en   (xstate_en_reg),
    .i_caps        (CAPS),
    .i_select      (select_reg),
    .o_layout      (lay)
  );

  // ========================================================================
  // ahb-lite slave: zero wait, always okay; reset only has to drop a pending write
  always_ff @(posedge i_clk) begin
    dp_write_reg <= !i_rst && addr_phase && i_hwrite;
    dp_addr_reg  <= i_haddr[7:0];
    o_hreadyout  <= 1'b1;
    o_hresp      <= 1'b0;
  end

  // read mux, unmapped addresses read as zero
  always_comb begin
    unique case (i_haddr[7:0])
      `REG_BASE_LO:     rd_value = encl_base_reg[31:0];
      `REG_BASE_HI:     rd_value = encl_base_reg[63:32];
      `REG_STACK_LO:    rd_value = stack_ofs_reg[31:0];
      `REG_STACK_HI:    rd_value = stack_ofs_reg[63:32];
      `REG_FRAME_SIZE:  rd_value = frame_size_reg;
      `REG_FRAME_INDEX: rd_value = frame_index_reg;
      `REG_SELECT:      rd_value = select_reg;
      `REG_XSTATE_EN:   rd_value = 32'(xstate_en_reg);
      `REG_CAPS:        rd_value = CAPS;
      `REG_STATUS:      rd_value = 32'(status_reg);
      `REG_MASK:        rd_value = 32'(mask_reg);
      `REG_STATE:       rd_value = {lay_reg.overlap, o_notify, 26'h0, state_reg};
      default:          rd_value = 32'h0;
    endcase
  end

  // read data is prepared in the address phase so it stands in the data phase
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_hrdata <= 32'h0;
    end else if (addr_phase && !i_hwrite) begin
      o_hrdata <= rd_value;
    end
  end

  // ========================================================================
  // software configuration; geometry is frozen per sequence, so late writes act next time, except the misc strobes, which follow select_reg live
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      encl_base_reg  <= 64'h0;
      stack_ofs_reg  <= 64'h0;
      frame_size_reg <= `RST_FRAME_SIZE;
      select_reg     <= 32'h0;
      xstate_en_reg  <= XS_COMPS'(`RST_XSTATE_EN);
      mask_reg       <= '0;
    end else if (sw_write) begin
      unique case (dp_addr_reg)
        `REG_BASE_LO:    encl_base_reg[31:0]  <= i_hwdata;
        `REG_BASE_HI:    encl_base_reg[63:32] <= i_hwdata;
        `REG_STACK_LO:   stack_ofs_reg[31:0]  <= i_hwdata;
        `REG_STACK_HI:   stack_ofs_reg[63:32] <= i_hwdata;
        `REG_FRAME_SIZE: frame_size_reg       <= i_hwdata;
        `REG_SELECT:     select_reg           <= i_hwdata & CAPS;
        `REG_XSTATE_EN:  xstate_en_reg        <= i_hwdata[XS_COMPS-1:0];
        `REG_MASK:       mask_reg             <= i_hwdata[`ST_WIDTH-1:0];
        default:         ;
      endcase
    end
  end

  // ========================================================================
  // index steps on exit and resume; hardware wins over software
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      frame_index_reg <= 32'h0;
    end else if (state_reg == S_WR_INFO && mem_done) begin
      frame_index_reg <= frame_index_reg + 32'h1;
    end else if (state_reg == S_IDLE && i_resume_req && frame_index_reg != 32'h0) begin
      frame_index_reg <= frame_index_reg - 32'h1;
    end else if (sw_write && dp_addr_reg == `REG_FRAME_INDEX) begin
      frame_index_reg <= i_hwdata;
    end
  end

  // ========================================================================
  // sticky status, write one to clear; a new event wins over the clear
  assign events[`ST_EXIT_DONE]   = state_reg == S_WR_INFO && mem_done;
  assign events[`ST_RESUME_DONE] = state_reg == S_IDLE && i_resume_req;
  assign events[`ST_LAYOUT_ERR]  = state_reg == S_IDLE && i_exit_req && lay.overlap;
  assign events[`ST_NOTIFY]      = state_reg == S_RD_INFO && mem_done
                                   && i_mem_rdata[8*`NOTIFY_BYTE + `NOTIFY_BIT];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_reg <= '0;
    end else if (sw_write && dp_addr_reg == `REG_STATUS) begin
      status_reg <= (status_reg & ~i_hwdata[`ST_WIDTH-1:0]) | events;
    end else begin
      status_reg <= status_reg | events;
    end
  end

  // level interrupt; folding in the events saves a cycle of latency
  always_ff @(posedge i_clk) begin
    o_irq <= !i_rst && (|((status_reg | events) & mask_reg));
  end

  // ========================================================================
  // sequence control
  // exit saves into the frame of the current index
  always_comb begin
    state_next = state_reg;
    step_last  = mem_done && cnt_reg == last_cnt;
    unique case (state_reg)
      S_IDLE: begin
        if (i_exit_req && !lay.overlap) begin
          state_next = S_XS;
        end else if (i_entry_req) begin
          state_next = S_EN_OSP;
        end
      end
      // with no misc region the gap is skipped untouched
      S_XS:      if (step_last) state_next = (lay_reg.misc_size != 64'h0) ? S_MISC : S_GPR;
      S_MISC:    if (step_last) state_next = S_GPR;
      S_GPR:     if (step_last) state_next = S_RD_OSP;
      S_RD_OSP:  if (mem_done) state_next = S_RD_OFP;
      S_RD_OFP:  if (mem_done) state_next = S_RD_INFO;
      S_RD_INFO: if (mem_done) state_next = S_WR_INFO;
      S_WR_INFO: if (mem_done) state_next = S_IDLE;
      S_EN_OSP:  if (mem_done) state_next = S_EN_OFP;
      S_EN_OFP:  if (mem_done) state_next = S_IDLE;
    endcase
  end

  // index of the last word of the current multi-word phase (word count minus one)
  always_comb begin
    unique case (state_reg)
      S_XS:    last_cnt = 16'(lay_reg.xs_size[18:3]) - 16'h1;
      S_MISC:  last_cnt = 16'(lay_reg.misc_size[18:3]) - 16'h1;
      S_GPR:   last_cnt = 16'd17;
      default: last_cnt = 16'h0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 16'h0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        cnt_reg <= 16'h0;
      end else if (mem_done) begin
        cnt_reg <= cnt_reg + 16'h1;
      end
    end
  end

  // geometry and core state are frozen when a sequence starts
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lay_reg   <= '0;
      saved_reg <= '0;
    end else if (state_reg == S_IDLE) begin
      lay_reg <= lay;
      if (i_exit_req && !lay.overlap) begin
        saved_reg <= i_state;
      end else if (i_entry_req) begin
        saved_reg.gpr[0] <= i_entry_ptrs.sp;
        saved_reg.gpr[1] <= i_entry_ptrs.fp;
      end
    end
  end

  // ========================================================================
  // request builder for the next memory word
  always_comb begin
    req_next       = '0;
    req_next.valid = 1'b1;
    req_next.write = 1'b1;
    req_next.strb  = 8'hff;
    unique case (state_reg)
      S_IDLE: req_next.valid = 1'b0;
      // extended state from the frame base, words taken from the core
      S_XS: begin
        req_next.addr  = lay_reg.frame_base + `XS_OFFSET + {45'h0, cnt_reg, 3'h0};
        req_next.wdata = i_xs_data;
      end
      // only selected components get byte strobes
      S_MISC: begin
        req_next.addr  = lay_reg.misc_base + {45'h0, cnt_reg, 3'h0};
        req_next.wdata = i_xs_data;
        req_next.strb  = select_reg[cnt_reg[5:1]] ? 8'hff : 8'h00;
      end
      S_GPR: begin
        req_next.addr = lay_reg.gpr_base + {45'h0, cnt_reg, 3'h0};
        if (cnt_reg < 16'd16) begin
          req_next.wdata = saved_reg.gpr[cnt_reg[3:0]];
        end else if (cnt_reg == 16'd16) begin
          req_next.wdata = saved_reg.flags;
        end else begin
          req_next.wdata = saved_reg.ip;
        end
      end
      // outside pointers come back on exit
      S_RD_OSP: begin
        req_next.write = 1'b0;
        req_next.addr  = lay_reg.gpr_base + `GPR_OSP_OFS;
      end
      S_RD_OFP: begin
        req_next.write = 1'b0;
        req_next.addr  = lay_reg.gpr_base + `GPR_OFP_OFS;
      end
      S_RD_INFO: begin
        req_next.write = 1'b0;
        req_next.addr  = lay_reg.gpr_base + `GPR_INFO_OFS;
      end
      // low four bytes only, reserved and notify bytes are kept
      S_WR_INFO: begin
        req_next.addr  = lay_reg.gpr_base + `GPR_INFO_OFS;
        req_next.wdata = {32'h0, saved_reg.exit_info};
        req_next.strb  = `INFO_STRB;
      end
      S_EN_OSP: begin
        req_next.addr  = lay_reg.gpr_base + `GPR_OSP_OFS;
        req_next.wdata = saved_reg.gpr[0];
      end
      S_EN_OFP: begin
        req_next.addr  = lay_reg.gpr_base + `GPR_OFP_OFS;
        req_next.wdata = saved_reg.gpr[1];
      end
    endcase
  end

  // request held until taken, then one idle cycle so the counter settles
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mem    <= '0;
      o_xs_pop <= 1'b0;
    end else begin
      o_xs_pop <= mem_done && (state_reg == S_XS || state_reg == S_MISC);
      if (mem_done) begin
        o_mem.valid <= 1'b0;
      end else if (!o_mem.valid) begin
        o_mem <= req_next;
      end
    end
  end

  // ========================================================================
  // restored pointers and notification outcome
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_restore       <= '0;
      o_restore_valid <= 1'b0;
      o_notify        <= 1'b0;
      o_busy          <= 1'b0;
    end else begin
      o_busy          <= state_next != S_IDLE;
      o_restore_valid <= state_reg == S_RD_OFP && mem_done;
      if (state_reg == S_RD_OSP && mem_done) o_restore.sp <= i_mem_rdata;
      if (state_reg == S_RD_OFP && mem_done) o_restore.fp <= i_mem_rdata;
      // only bit 0 of byte 167 counts
      if (state_reg == S_RD_INFO && mem_done) o_notify <= i_mem_rdata[8*`NOTIFY_BYTE+`NOTIFY_BIT];
    end
  end

endmodule : frame_engine
`default_nettype wire

// *** tb/frame_engine_chk.sv ***
// port assertions of the save-frame engine
`timescale 1ns/10ps
`default_nettype none
module frame_engine_chk
  import frame_pkg::*;
(
  input wire logic     i_clk,
  input wire logic     i_rst,
  input wire mem_req_t o_mem,
  input wire logic     i_mem_ready,
  input wire logic     o_xs_pop,
  input wire logic     o_restore_valid,
  input wire logic     o_notify,
  input wire logic     o_busy,
  input wire logic     o_hreadyout,
  input wire logic     o_hresp
);
  // ==========
  // last accepted address, ties the pointer reads and the exit word together
  logic [63:0] last_reg;
  logic        acc;
  assign acc = o_mem.valid && i_mem_ready;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last_reg <= 64'h0;
    end else if (acc) begin
      last_reg <= o_mem.addr;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_rd;
    acc && !o_mem.write;
  endsequence
  sequence s_info;
    acc && o_mem.write && o_mem.strb == 8'h0f;
  endsequence
  a_req_held: assert property (o_mem.valid && !i_mem_ready |=> $stable(o_mem))
    else $error("request changed before acceptance");
  a_busy_cover: assert property (o_mem.valid |-> o_busy)
    else $error("memory request while idle");
  a_word_align: assert property (o_mem.valid |-> o_mem.addr[2:0] == 3'h0)
    else $error("unaligned memory word");
  a_read_stride: assert property (s_rd |-> o_mem.addr == last_reg + 64'h8)
    else $error("read not eight above last word");
  a_info_place: assert property (s_info |-> o_mem.addr == last_reg)
    else $error("exit word away from its read");
  a_pop_follow: assert property (o_xs_pop |-> $past(acc) && $past(o_mem.write))
    else $error("pop without accepted write");
  a_restore_pulse: assert property (o_restore_valid |=> !o_restore_valid)
    else $error("restore strobe too long");
  a_notify_move: assert property ($changed(o_notify) |-> o_busy || $past(o_busy))
    else $error("notify changed while idle");
  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus not ready or not okay");
  a_idle_gap: assert property (acc |=> !o_mem.valid)
    else $error("no idle cycle between words");
endmodule : frame_engine_chk
bind frame_engine frame_engine_chk chk (.i_clk(i_clk), .i_rst(i_rst), .o_mem(o_mem),
  .i_mem_ready(i_mem_ready), .o_xs_pop(o_xs_pop), .o_restore_valid(o_restore_valid),
  .o_notify(o_notify), .o_busy(o_busy), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp));
`default_nettype wire

// *** tb/frame_mem_model.sv ***
// enclave memory model answering the engine's word requests
`timescale 1ns/10ps
`default_nettype none
module frame_mem_model
  import frame_pkg::*;
(
  input  wire logic     i_clk,
  input  wire mem_req_t i_req,
  output logic          o_ready,
  output logic [63:0]   o_rdata
);
  // ==========
  // word store by byte address; a word never written stays absent
  logic [63:0] m [logic [63:0]];
  logic [63:0] last_q = 64'h0;
  logic [63:0] w;
  int          dly = 0;
  int          cnt = 0;
  assign o_ready = i_req.valid && (cnt >= dly);
  // an unanswered line shows the inverse of its last value, never a stale copy
  always_comb begin
    o_rdata = ~last_q;
    if (o_ready && m.exists(i_req.addr)) begin
      o_rdata = m[i_req.addr];
    end
  end
  // merge written bytes; zero strobe leaves the word absent
  always @(posedge i_clk) begin
    cnt <= (i_req.valid && !o_ready) ? cnt + 1 : 0;
    if (o_ready && i_req.write && i_req.strb != 8'h0) begin
      w = m.exists(i_req.addr) ? m[i_req.addr] : 64'h0;
      for (int b = 0; b < 8; b++) begin
        if (i_req.strb[b]) w[8*b+:8] = i_req.wdata[8*b+:8];
      end
      m[i_req.addr] = w;
    end
    if (o_ready) last_q <= o_rdata;
  end
endmodule : frame_mem_model
`default_nettype wire

// *** tb/test_frame_engine.sv ***
// self-checking bench of the save-frame engine
`timescale 1ns/10ps
`default_nettype none
`include "frame_defines.svh"
module test_frame_engine
  import frame_pkg::*;
  ;
  // ==========
  logic          clk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic          exit_req = 0, entry_req = 0, resume_req = 0;
  logic [31:0]   haddr = 0, hwdata = 0, hrdata;
  logic [1:0]    htrans = 0;
  logic [63:0]   r, mrdata, xs_data, pops = 0;
  logic          hready, hresp, xs_pop, mrdy, rvalid, notify, busy, irq;
  arch_state_t   st = '0;
  outside_ptrs_t ptrs = '0, restore;
  mem_req_t      mreq;
  int            fails = 0, checks = 0, rvs = 0;
  // page-aligned frame base; one-page frames end the gpr region on a page end
  localparam logic [63:0] FB = 64'h0010_2000;
  localparam logic [63:0] GB = FB + 64'h0f50;
  always #50 clk = ~clk;
  // core shows the next word as soon as the previous one is popped
  always @(posedge clk) if (xs_pop) pops <= pops + 64'h1;
  // restore strobes seen, each one counted at the edge after it rises
  always @(posedge clk) if (rvalid) rvs++;
  assign xs_data = 64'h1000 + pops + {63'h0, xs_pop};
  frame_engine dut (.i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_exit_req(exit_req), .i_state(st), .i_entry_req(entry_req), .i_entry_ptrs(ptrs),
    .i_resume_req(resume_req), .i_xs_data(xs_data), .o_xs_pop(xs_pop), .o_mem(mreq),
    .i_mem_ready(mrdy), .i_mem_rdata(mrdata), .o_restore(restore),
    .o_restore_valid(rvalid), .o_notify(notify), .o_busy(busy), .o_irq(irq));
  frame_mem_model mem (.i_clk(clk), .i_req(mreq), .o_ready(mrdy), .o_rdata(mrdata));
  task close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // single word transfer, address held until ready, data taken at the second ready
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    @(posedge clk); while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0; hwdata <= d;
    @(posedge clk); while (hready !== 1'b1) @(posedge clk);
    r = {32'h0, hrdata};
  endtask : ahb
  task pulse_wait(input int k);
    int n;
    n = 0;
    @(posedge clk); exit_req <= 0; entry_req <= 0; resume_req <= 0;
    // busy launched at the taking edge is only readable one edge later
    @(posedge clk);
    while (busy !== 1'b0 && n < 3000) begin @(posedge clk); n++; end
    if (n >= 3000) fails++;
    repeat (k) @(posedge clk);
  endtask : pulse_wait
  task t_regs;
    @(posedge clk);
    ahb(0, `REG_FRAME_SIZE, 0); chk(r, 64'h1000);
    ahb(0, `REG_XSTATE_EN, 0); chk(r, 64'h3);
    ahb(1, `REG_CAPS, 0); ahb(0, `REG_CAPS, 0); chk(r, 64'h1);
    ahb(0, 8'h40, 0); chk(r, 64'h0);
    ahb(1, `REG_BASE_LO, 32'h0010_0000); ahb(1, `REG_BASE_HI, 0);
    ahb(1, `REG_STACK_LO, 32'h2000); ahb(1, `REG_STACK_HI, 0);
    ahb(1, `REG_SELECT, 1); ahb(1, `REG_MASK, 32'hf);
    ahb(0, `REG_BASE_LO, 0); chk(r, 64'h0010_0000);
    $display("test regs done");
  endtask : t_regs
  task t_entry;
    ptrs <= '{64'h7000_0010, 64'h7000_0020}; entry_req <= 1;
    pulse_wait(0);
    chk(mem.m[GB+144], 64'h7000_0010);
    chk(mem.m[GB+152], 64'h7000_0020);
    $display("test entry done");
  endtask : t_entry
  task t_exit;
    mem.dly = 2;
    mem.m[GB+160] = 64'h01aa_bbcc_0000_0000;
    for (int i = 0; i < 16; i++) st.gpr[i] <= 64'h100 + 64'(i);
    st.flags <= 64'h202; st.ip <= 64'h4000; st.exit_info <= 32'h8000_030e; exit_req <= 1;
    pulse_wait(2);
    for (int i = 0; i < 16; i++) chk(mem.m[GB+64'(8*i)], 64'h100 + 64'(i));
    chk(mem.m[GB+128], 64'h202);
    chk(mem.m[GB+136], 64'h4000);
    chk(mem.m[GB+160], 64'h01aa_bbcc_8000_030e);
    chk(restore.sp, 64'h7000_0010);
    chk(restore.fp, 64'h7000_0020);
    chk(64'(rvs), 64'h1);
    chk({63'h0, notify}, 64'h1);
    chk(mem.m[FB], 64'h1000);
    chk(64'(mem.m.exists(FB+64'h238)), 64'h1);
    chk(64'(mem.m.exists(FB+64'h240)), 64'h0);
    chk(64'(mem.m.exists(GB-64'h10)), 64'h1);
    ahb(0, `REG_FRAME_INDEX, 0); chk(r, 64'h1);
    ahb(0, `REG_STATUS, 0); chk(r & 64'h1, 64'h1);
    chk({63'h0, irq}, 64'h1);
    ahb(1, `REG_STATUS, 32'hf); repeat (2) @(posedge clk); chk({63'h0, irq}, 64'h0);
    $display("test exit done");
  endtask : t_exit
  task t_second;
    mem.dly = 0;
    mem.m[GB+64'h1000+160] = 64'hfe00_0000_0000_0000;
    st.ip <= 64'h5000; exit_req <= 1;
    pulse_wait(2);
    chk(mem.m[GB+64'h1000+136], 64'h5000);
    chk(64'(rvs), 64'h2);
    chk({63'h0, notify}, 64'h0);
    ahb(0, `REG_FRAME_INDEX, 0); chk(r, 64'h2);
    $display("test second exit done");
  endtask : t_second
  task t_resume;
    ahb(1, `REG_MASK, 0); resume_req <= 1;
    pulse_wait(2);
    chk({63'h0, irq}, 64'h0);
    ahb(0, `REG_FRAME_INDEX, 0); chk(r, 64'h1);
    ahb(0, `REG_STATUS, 0); chk(r & 64'h2, 64'h2);
    ahb(1, `REG_MASK, 2); repeat (2) @(posedge clk); chk({63'h0, irq}, 64'h1);
    ahb(1, `REG_STATUS, 2); repeat (2) @(posedge clk); chk({63'h0, irq}, 64'h0);
    // a frame too small for its regions refuses the exit
    ahb(1, `REG_FRAME_SIZE, 32'h100); exit_req <= 1;
    pulse_wait(0);
    ahb(0, `REG_STATUS, 0); chk(r & 64'h4, 64'h4);
    ahb(0, `REG_FRAME_INDEX, 0); chk(r, 64'h1);
    $display("test resume done");
  endtask : t_resume
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    t_regs; t_entry; t_exit; t_second; t_resume;
    close_out;
  end
  // watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out;
  end
endmodule : test_frame_engine
`default_nettype wire
